// ===== dcache_ctl_cfg.svh
// Purpose: Offsets, field positions and reset values of the data cache control block.
// Assumes: 32-bit byte addresses on the register bus, one aligned word per register.
// Notes: Definitions only; included by bare name.
`ifndef DCACHE_CTL_CFG_SVH
`define DCACHE_CTL_CFG_SVH

// Register byte addresses.
`define OFS_SIZE_CFG 32'h0184_0040
`define OFS_FREEZE_CTL 32'h0184_0044
`define OFS_BLK_WBINV_BASE 32'h0184_4030
`define OFS_BLK_WBINV_CNT 32'h0184_4034
`define OFS_BLK_WB_BASE 32'h0184_4040
`define OFS_BLK_WB_CNT 32'h0184_4044
`define OFS_BLK_INV_BASE 32'h0184_4048
`define OFS_BLK_INV_CNT 32'h0184_404C
`define OFS_GLB_WB 32'h0184_5040
`define OFS_GLB_WBINV 32'h0184_5044
`define OFS_GLB_INV 32'h0184_5048

// Field positions.
`define BIT_FREEZE 0
`define BIT_PREV_FREEZE 16
`define BIT_CMD 0
`define CNT_MSB 15

// Operation indices shared by the global and the block engines.
`define OP_INV 2'h0
`define OP_WB 2'h1
`define OP_WBINV 2'h2

// Reset values and the per-word address step.
`define RST_SIZE 3'h7
`define RST_CNT 16'h0000
`define WORD_STEP 32'h0000_0004

`endif

// ===== dcache_ctl_pkg.sv
// Purpose: Types shared by the data cache control block.
// Assumes: Three coherence operations and a two-phase bus answer.
// Notes: Numbers live in dcache_ctl_cfg.svh; this package holds only types.
package dcache_ctl_pkg;

   // Bus answer phase: take the request, then show ack for one cycle.
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_state_t;

   // Register decode result.
   typedef enum logic [3:0] {
      R_NONE = 4'h0,
      R_SIZE = 4'h1,
      R_FREEZE = 4'h2,
      R_GLB_INV = 4'h3,
      R_GLB_WB = 4'h4,
      R_GLB_WBINV = 4'h5,
      R_BASE_INV = 4'h6,
      R_CNT_INV = 4'h7,
      R_BASE_WB = 4'h8,
      R_CNT_WB = 4'h9,
      R_BASE_WBINV = 4'hA,
      R_CNT_WBINV = 4'hB
   } reg_sel_t;

   // Complete state of the block.
   typedef struct packed {
      bus_state_t bus;
      logic ack;
      logic [31:0] rdat;
      logic [2:0] size;
      logic freeze;
      logic prev_freeze;
      logic [2:0] glb;
      logic [2:0][15:0] cnt;
      logic [2:0][31:0] base;
      logic blk_req;
      logic [1:0] blk_kind;
      logic [31:0] blk_addr;
      logic cpu_stall;
      logic dma_stall;
   } ctl_state_t;

endpackage

// ===== dcache_ctl.sv
// Purpose: Level-one data cache control registers, coherence command sequencing and
//          bank-conflict detection for the eight-bank data memory.
// Assumes: Classic Wishbone slave; priv_super_i qualifies each bus request.
// Notes: Stall outputs are registered and refer to the accesses of the previous cycle.
//
// Operation
// RULE_01: Bit 16 read-only, holds previous freeze value.
// RULE_02: Bit 0 selects normal or freeze mode.
// RULE_03: Global invalidate bit invalidates every line.
// RULE_04: Global writeback writes dirty lines, keeps valid.
// RULE_05: Global writeback-invalidate writes back then invalidates.
// RULE_06: Write-only 32-bit base per block operation.
// RULE_07: Sixteen-bit word count, upper bits zero.
// RULE_08: Only supervisor may change cache size.
// RULE_09: Only supervisor may issue global invalidate.
// RULE_10: Freeze control writable from both modes.
// RULE_11: Access rights enforced per privilege level.
// RULE_12: Eight single-ported 32-bit banks shared.
// RULE_13: Address bits 4:2 bank, 1:0 byte.
// RULE_14: Same-bank pair stalls one cycle normally.
// RULE_15: Disjoint writes to same word never stall.
// RULE_16: Reads of same word never stall.
// RULE_17: One nonaligned access never stalls itself.
// RULE_18: Read and write together always stall.
// RULE_19: CPU and DMA on one bank: one stalls.
// RULE_20: Non-zero word count write starts operation.
// RULE_21: Word count decrements to zero when done.
// RULE_22: Global command bit self-clears when finished.
// RULE_23: Fixed priority: CPU wins, DMA stalls.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "dcache_ctl_cfg.svh"

module dcache_ctl #(
   parameter logic [2:0] SIZE_RESET = `RST_SIZE,
   parameter int BANKS = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic priv_super_i,
   output logic [2:0] cache_size_o,
   output logic freeze_enable_o,
   output logic [2:0] glb_cmd_o,
   input wire logic [2:0] glb_done_i,
   output logic blk_req_o,
   output logic [1:0] blk_kind_o,
   output logic [31:0] blk_addr_o,
   input wire logic blk_ack_i,
   input wire logic big_endian_i,
   input wire logic pa_vld_i,
   input wire logic pa_we_i,
   input wire logic [31:0] pa_addr_i,
   input wire logic [1:0] pa_size_i,
   input wire logic pb_vld_i,
   input wire logic pb_we_i,
   input wire logic [31:0] pb_addr_i,
   input wire logic [1:0] pb_size_i,
   input wire logic split_i,
   input wire logic dm_vld_i,
   input wire logic [31:0] dm_addr_i,
   output logic cpu_stall_o,
   output logic dma_stall_o
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   // The bank decode is fixed to address bits 4:2, so only eight banks can be served.
   if (BANKS != 8) begin : g_bank_check
      $error("BANKS must be 8 for the bit 4:2 bank decode.");
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Maps a byte address onto a register selector.
   function automatic dcache_ctl_pkg::reg_sel_t reg_decode(input logic [31:0] a);
      dcache_ctl_pkg::reg_sel_t s;
      case (a)
         `OFS_SIZE_CFG: s = dcache_ctl_pkg::R_SIZE;
         `OFS_FREEZE_CTL: s = dcache_ctl_pkg::R_FREEZE;
         `OFS_GLB_INV: s = dcache_ctl_pkg::R_GLB_INV;
         `OFS_GLB_WB: s = dcache_ctl_pkg::R_GLB_WB;
         `OFS_GLB_WBINV: s = dcache_ctl_pkg::R_GLB_WBINV;
         `OFS_BLK_INV_BASE: s = dcache_ctl_pkg::R_BASE_INV;
         `OFS_BLK_INV_CNT: s = dcache_ctl_pkg::R_CNT_INV;
         `OFS_BLK_WB_BASE: s = dcache_ctl_pkg::R_BASE_WB;
         `OFS_BLK_WB_CNT: s = dcache_ctl_pkg::R_CNT_WB;
         `OFS_BLK_WBINV_BASE: s = dcache_ctl_pkg::R_BASE_WBINV;
         `OFS_BLK_WBINV_CNT: s = dcache_ctl_pkg::R_CNT_WBINV;
         default: s = dcache_ctl_pkg::R_NONE;
      endcase
      return s;
   endfunction

   // Byte lanes touched by an access; big-endian mode mirrors the lanes in the word.
   function automatic logic [3:0] byte_mask(input logic [1:0] off, input logic [1:0] sz,
                                            input logic big);
      logic [3:0] m;
      m = (sz == 2'h0) ? 4'h1 : ((sz == 2'h1) ? 4'h3 : 4'hF);
      m = 4'(m << off);
      if (big) begin
         m = {m[0], m[1], m[2], m[3]};
      end
      return m;
   endfunction

   // Bank number of an aligned access.
   function automatic logic [2:0] bank_of(input logic [31:0] a);
      return a[4:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // State and bus request decode.

   dcache_ctl_pkg::ctl_state_t st_r; // Registered state.
   dcache_ctl_pkg::ctl_state_t st_nxt; // Next state.
   dcache_ctl_pkg::reg_sel_t sel; // Register addressed by the bus.
   logic take; // A new bus request is taken this cycle.
   logic wr; // The taken request is a write.
   logic [31:0] wmask; // Byte-lane mask from wb_sel_i.
   logic [31:0] wdat; // Write data with unselected byte lanes forced to zero.
   logic [3:0] ma; // Byte lanes of port A.
   logic [3:0] mb; // Byte lanes of port B.
   logic same_bank; // Ports A and B hit one bank.
   logic same_word; // Ports A and B hit one word.
   logic port_conflict; // Ports A and B need a stall.
   logic dma_conflict; // DMA shares a bank with a CPU port.

   assign sel = reg_decode(wb_adr_i);
   assign take = wb_cyc_i && wb_stb_i && (st_r.bus == dcache_ctl_pkg::BUS_IDLE);
   assign wr = take && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat = wb_dat_i & wmask;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Bank-conflict detection.

   // Compares the two CPU ports and the DMA port; purely combinational, registered below.
   always_comb begin
      ma = byte_mask(pa_addr_i[1:0], pa_size_i, big_endian_i);
      mb = byte_mask(pb_addr_i[1:0], pb_size_i, big_endian_i);
      // RULE_13: bank from bits 4:2.
      same_bank = bank_of(pa_addr_i) == bank_of(pb_addr_i);
      same_word = pa_addr_i[31:2] == pb_addr_i[31:2];
      port_conflict = 1'b0;
      // RULE_17: split access exempt.
      if (pa_vld_i && pb_vld_i && same_bank && !split_i) begin
         // RULE_14: same-bank pair stalls.
         port_conflict = 1'b1;
         // RULE_18: mixed direction always stalls.
         if (pa_we_i != pb_we_i) begin
            port_conflict = 1'b1;
         // RULE_15: disjoint writes share a word.
         end else if (pa_we_i && same_word && ((ma & mb) == 4'h0)) begin
            port_conflict = 1'b0;
         // RULE_16: reads share a word freely.
         end else if (!pa_we_i && same_word) begin
            port_conflict = 1'b0;
         end
      end
      // RULE_19: DMA against either CPU bank.
      dma_conflict = dm_vld_i &&
                     ((pa_vld_i && (bank_of(dm_addr_i) == bank_of(pa_addr_i))) ||
                      (pb_vld_i && (bank_of(dm_addr_i) == bank_of(pb_addr_i))));
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // One process builds every field; later assignments override earlier ones, so a
   // software write beats a hardware clear or decrement in the same cycle.
   always_comb begin
      int k;
      k = 0;
      st_nxt = st_r;

      // Bus answer: ack exactly one cycle after the request, then one idle cycle.
      st_nxt.ack = 1'b0;
      st_nxt.bus = dcache_ctl_pkg::BUS_IDLE;
      if (take) begin
         st_nxt.ack = 1'b1;
         st_nxt.bus = dcache_ctl_pkg::BUS_ACK;
      end

      // RULE_22: engine finish clears the command.
      st_nxt.glb = st_r.glb & ~glb_done_i;

      // RULE_21: each acknowledged word steps the block.
      if (st_r.blk_req && blk_ack_i) begin
         st_nxt.cnt[st_r.blk_kind] = st_r.cnt[st_r.blk_kind] - 16'h0001;
         st_nxt.base[st_r.blk_kind] = st_r.base[st_r.blk_kind] + `WORD_STEP;
      end

      // Register reads; unmapped addresses and write-only bases read as zero.
      if (take && !wb_we_i) begin
         st_nxt.rdat = 32'h0000_0000;
         case (sel)
            dcache_ctl_pkg::R_SIZE: st_nxt.rdat[2:0] = st_r.size;
            dcache_ctl_pkg::R_FREEZE: begin
               st_nxt.rdat[`BIT_FREEZE] = st_r.freeze;
               st_nxt.rdat[`BIT_PREV_FREEZE] = st_r.prev_freeze;
            end
            dcache_ctl_pkg::R_GLB_INV: st_nxt.rdat[`BIT_CMD] = st_r.glb[`OP_INV];
            dcache_ctl_pkg::R_GLB_WB: st_nxt.rdat[`BIT_CMD] = st_r.glb[`OP_WB];
            dcache_ctl_pkg::R_GLB_WBINV: st_nxt.rdat[`BIT_CMD] = st_r.glb[`OP_WBINV];
            // RULE_07: count in bits 15:0.
            dcache_ctl_pkg::R_CNT_INV: st_nxt.rdat[`CNT_MSB:0] = st_r.cnt[`OP_INV];
            dcache_ctl_pkg::R_CNT_WB: st_nxt.rdat[`CNT_MSB:0] = st_r.cnt[`OP_WB];
            dcache_ctl_pkg::R_CNT_WBINV: st_nxt.rdat[`CNT_MSB:0] = st_r.cnt[`OP_WBINV];
            default: st_nxt.rdat = 32'h0000_0000;
         endcase
      end

      // Register writes; RULE_11: rights checked per register.
      if (wr) begin
         case (sel)
            dcache_ctl_pkg::R_SIZE: begin
               // RULE_08: user writes are dropped.
               if (priv_super_i && wb_sel_i[0]) begin
                  st_nxt.size = wdat[2:0];
               end
            end
            dcache_ctl_pkg::R_FREEZE: begin
               // RULE_10: either mode may write.
               if (wb_sel_i[0]) begin
                  // RULE_02: bit 0 selects freeze.
                  st_nxt.freeze = wdat[`BIT_FREEZE];
                  // RULE_01: remember value before a change.
                  if (wdat[`BIT_FREEZE] != st_r.freeze) begin
                     st_nxt.prev_freeze = st_r.freeze;
                  end
               end
            end
            dcache_ctl_pkg::R_GLB_INV: begin
               // RULE_09: supervisor only.
               // RULE_03: request global invalidate.
               if (priv_super_i && wdat[`BIT_CMD]) begin
                  st_nxt.glb[`OP_INV] = 1'b1;
               end
            end
            dcache_ctl_pkg::R_GLB_WB: begin
               // RULE_04: request global writeback.
               if (wdat[`BIT_CMD]) begin
                  st_nxt.glb[`OP_WB] = 1'b1;
               end
            end
            dcache_ctl_pkg::R_GLB_WBINV: begin
               // RULE_05: request writeback-invalidate.
               if (wdat[`BIT_CMD]) begin
                  st_nxt.glb[`OP_WBINV] = 1'b1;
               end
            end
            // RULE_06: base is write-only, full word.
            dcache_ctl_pkg::R_BASE_INV: st_nxt.base[`OP_INV] = wdat;
            dcache_ctl_pkg::R_BASE_WB: st_nxt.base[`OP_WB] = wdat;
            dcache_ctl_pkg::R_BASE_WBINV: st_nxt.base[`OP_WBINV] = wdat;
            // RULE_20: a count write arms the operation.
            dcache_ctl_pkg::R_CNT_INV: st_nxt.cnt[`OP_INV] = wdat[`CNT_MSB:0];
            dcache_ctl_pkg::R_CNT_WB: st_nxt.cnt[`OP_WB] = wdat[`CNT_MSB:0];
            dcache_ctl_pkg::R_CNT_WBINV: st_nxt.cnt[`OP_WBINV] = wdat[`CNT_MSB:0];
            default: st_nxt.size = st_nxt.size;
         endcase
      end

      // Block engine request: lowest-numbered operation with words left goes first.
      // RULE_20: non-zero count raises the request.
      st_nxt.blk_req = 1'b0;
      st_nxt.blk_kind = `OP_INV;
      for (k = 2; k >= 0; k--) begin
         if (st_nxt.cnt[k] != `RST_CNT) begin
            st_nxt.blk_req = 1'b1;
            st_nxt.blk_kind = 2'(k);
         end
      end
      st_nxt.blk_addr = st_nxt.base[st_nxt.blk_kind];

      // RULE_23: CPU has priority, DMA stalls.
      st_nxt.dma_stall = dma_conflict;
      st_nxt.cpu_stall = port_conflict;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // State register.

   // Synchronous reset; base registers clear too although software cannot see them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.size <= SIZE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs, each taken straight from a state flop.

   // RULE_12: stall flags guard the eight single-ported banks.
   assign wb_dat_o = st_r.rdat;
   assign wb_ack_o = st_r.ack;
   assign cache_size_o = st_r.size;
   assign freeze_enable_o = st_r.freeze;
   assign glb_cmd_o = st_r.glb;
   assign blk_req_o = st_r.blk_req;
   assign blk_kind_o = st_r.blk_kind;
   assign blk_addr_o = st_r.blk_addr;
   assign cpu_stall_o = st_r.cpu_stall;
   assign dma_stall_o = st_r.dma_stall;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions and covers.

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_prev_freeze_kept: assert property ( // RULE_01
      (wr && sel == dcache_ctl_pkg::R_FREEZE && wb_sel_i[0] && wb_dat_i[0] != st_r.freeze)
      |=> (st_r.prev_freeze == $past(st_r.freeze)) && (st_r.freeze != st_r.prev_freeze))
      else $error("Previous freeze bit did not capture the old value.");

   a_freeze_user_write: assert property ( // RULE_10
      (wr && !priv_super_i && sel == dcache_ctl_pkg::R_FREEZE && wb_sel_i[0])
      |=> ##1 freeze_enable_o == $past(wb_dat_i[0], 2))
      else $error("User write to freeze control had no effect.");

   a_size_user_blocked: assert property ( // RULE_08
      (wr && !priv_super_i && sel == dcache_ctl_pkg::R_SIZE) |=> $stable(cache_size_o))
      else $error("User mode changed the cache size.");

   a_inv_user_blocked: assert property ( // RULE_09
      (wr && !priv_super_i && sel == dcache_ctl_pkg::R_GLB_INV && !st_r.glb[0])
      |=> !glb_cmd_o[0])
      else $error("User mode started a global invalidate.");

   a_glb_self_clear: assert property ( // RULE_22
      (st_r.glb[1] && glb_done_i[1] && !(wr && sel == dcache_ctl_pkg::R_GLB_WB))
      |=> !glb_cmd_o[1])
      else $error("Global writeback bit did not clear on completion.");

   a_count_steps: assert property ( // RULE_21
      (st_r.blk_req && blk_ack_i && !wr)
      |=> st_r.cnt[$past(st_r.blk_kind)] == $past(st_r.cnt[st_r.blk_kind]) - 16'h0001)
      else $error("Word count did not step down by one.");

   a_count_starts: assert property ( // RULE_20
      (wr && sel == dcache_ctl_pkg::R_CNT_WB && wb_sel_i == 4'hF && wb_dat_i[15:0] != 16'h0)
      |=> blk_req_o ##1 wb_ack_o == 1'b0)
      else $error("Non-zero word count did not start a block operation.");

   a_mixed_stall: assert property ( // RULE_18
      (pa_vld_i && pb_vld_i && !split_i && pa_addr_i[4:2] == pb_addr_i[4:2] &&
       pa_we_i != pb_we_i) |=> cpu_stall_o)
      else $error("Read and write on one bank did not stall.");

   a_read_share: assert property ( // RULE_16
      (pa_vld_i && pb_vld_i && !pa_we_i && !pb_we_i && pa_addr_i[31:2] == pb_addr_i[31:2])
      |=> !cpu_stall_o)
      else $error("Two reads of one word stalled.");

   a_dma_yields: assert property ( // RULE_19
      (dm_vld_i && pa_vld_i && dm_addr_i[4:2] == pa_addr_i[4:2]) |=> dma_stall_o)
      else $error("DMA did not stall on a bank shared with the CPU.");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("Bus ack stood for more than one cycle.");

   c_block_done: cover property (
      blk_req_o ##1 !blk_req_o);
   c_write_share: cover property (
      pa_vld_i && pb_vld_i && pa_we_i && pb_we_i && pa_addr_i[31:2] == pb_addr_i[31:2]
      ##1 !cpu_stall_o);
   c_freeze_toggle: cover property (
      freeze_enable_o ##1 !freeze_enable_o);
   c_global_inv: cover property (
      glb_cmd_o[0] ##[1:20] !glb_cmd_o[0]);

endmodule

// ===== coh_engine_model.sv
// Purpose: Far-side coherence engine answering global and block requests.
// Assumes: One clock; slow_i adds five idle cycles before each answer.
// Notes: Answers are one-cycle pulses, never held, so streaming is not exercised.
`timescale 1ns/1ns
module coh_engine_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic [2:0] glb_cmd_i,
   output logic [2:0] glb_done_o,
   input wire logic blk_req_i,
   output logic blk_ack_o
);
   // Wait counters; index 3 serves the block word requests.
   logic [3:0] wait_r [4];
   logic [3:0] done_r;
   logic [3:0] pend;
   // A pulse just given is not pending, so one request never gets two answers.
   assign pend = {blk_req_i, glb_cmd_i} & ~done_r;
   assign glb_done_o = done_r[2:0];
   assign blk_ack_o = done_r[3];
   ////////////////////////////////////////////////////////////////////////////////
   // Count idle cycles per request, then pulse its answer.
   always @(posedge clk_i) begin
      for (int b = 0; b < 4; b++) begin
         if (rst_i || !pend[b]) begin
            wait_r[b] <= 4'h0;
            done_r[b] <= 1'b0;
         end else if (wait_r[b] >= (slow_i ? 4'h5 : 4'h0)) begin
            wait_r[b] <= 4'h0;
            done_r[b] <= 1'b1;
         end else begin
            wait_r[b] <= wait_r[b] + 4'h1;
         end
      end
   end
endmodule

// ===== test_data_cache_control_banking.sv
// Purpose: Self-checking bench for cache control registers and bank stalls.
// Assumes: Bus ack one cycle after the take; stall outputs lag one cycle.
// Notes: A narrow random address window forces many bank conflicts.
`timescale 1ns/1ns
`include "dcache_ctl_cfg.svh"
module test_data_cache_control_banking;
   logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, priv = 1'b0, wb_ack;
   logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, wb_rdat, blk_addr;
   logic [3:0] wb_sel = 4'h0;
   logic [2:0] size_o, glb_cmd, glb_done;
   logic frz, blk_req, blk_ack, cpu_stall, dma_stall;
   logic [1:0] blk_kind;
   // Port pair and DMA stimulus.
   logic big = 1'b0, split = 1'b0, pa_vld = 1'b0, pa_we = 1'b0, pb_vld = 1'b0, pb_we = 1'b0;
   logic dm_vld = 1'b0;
   logic [1:0] pa_size = 2'h0, pb_size = 2'h0;
   logic [31:0] pa_addr = 32'h0, pb_addr = 32'h0, dm_addr = 32'h0;
   // Bench model state: expected block word addresses wait in a queue.
   int n_errors = 0, tests_run = 0, cycles = 0;
   logic [31:0] r = 32'h11E9, exp_k = 32'h0;
   logic [31:0] exp_q [$];
   localparam logic [31:0] RA [10] = '{`OFS_SIZE_CFG, `OFS_FREEZE_CTL, `OFS_GLB_INV,
      `OFS_GLB_WB, `OFS_GLB_WBINV, `OFS_BLK_INV_CNT, `OFS_BLK_WB_CNT, `OFS_BLK_WBINV_CNT,
      `OFS_BLK_WB_BASE, 32'h0184_4050};
   localparam logic [31:0] GA [3] = '{`OFS_GLB_INV, `OFS_GLB_WB, `OFS_GLB_WBINV};
   localparam logic [31:0] CA [3] = '{`OFS_BLK_INV_CNT, `OFS_BLK_WB_CNT, `OFS_BLK_WBINV_CNT};
   localparam logic [31:0] BA [3] = '{`OFS_BLK_INV_BASE, `OFS_BLK_WB_BASE, `OFS_BLK_WBINV_BASE};

   dcache_ctl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .priv_super_i(priv), .cache_size_o(size_o),
      .freeze_enable_o(frz), .glb_cmd_o(glb_cmd), .glb_done_i(glb_done), .blk_req_o(blk_req),
      .blk_kind_o(blk_kind), .blk_addr_o(blk_addr), .blk_ack_i(blk_ack), .big_endian_i(big),
      .pa_vld_i(pa_vld), .pa_we_i(pa_we), .pa_addr_i(pa_addr), .pa_size_i(pa_size),
      .pb_vld_i(pb_vld), .pb_we_i(pb_we), .pb_addr_i(pb_addr), .pb_size_i(pb_size),
      .split_i(split), .dm_vld_i(dm_vld), .dm_addr_i(dm_addr), .cpu_stall_o(cpu_stall),
      .dma_stall_o(dma_stall));
   coh_engine_model eng (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .glb_cmd_i(glb_cmd),
      .glb_done_o(glb_done), .blk_req_i(blk_req), .blk_ack_o(blk_ack));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, timeout and helpers.
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_sim();
      end
   end
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Aligned address in a 64-byte window for the given access size.
   function automatic logic [31:0] al(input logic [31:0] x, input logic [1:0] s);
      return 32'h0080_0000 | (x[5:0] & (s == 2'h0 ? 6'h3F : s == 2'h1 ? 6'h3E : 6'h3C));
   endfunction
   function automatic logic [3:0] ln(input logic [31:0] a, input logic [1:0] s);
      return s == 2'h0 ? 4'h1 << a[1:0] : s == 2'h1 ? 4'h3 << a[1:0] : 4'hF;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; entered right after an edge, leaves after one idle edge.
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
         input logic s, output logic [31:0] q);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel, priv} <= {2'h3, w, a, d, 4'hF, s};
      @(posedge clk_i);
      while (wb_ack !== 1'b1) @(posedge clk_i);
      q = wb_rdat;
      {wb_cyc, wb_stb} <= 2'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic s);
      logic [31:0] q;
      bus(a, 1'b1, d, s, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, 1'b0, q);
      chk(q, e);
   endtask
   task automatic end_sim();
      $display("mismatches=%0d comparisons=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Every consumed block word must be the next expected address and kind.
   always @(posedge clk_i) begin
      if (blk_req === 1'b1 && blk_ack === 1'b1) begin
         chk(blk_addr, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF_FFFF);
         chk({30'h0, blk_kind}, exp_k);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [31:0] aa, ab, ad, fm, pm, n;
      logic [1:0] sa, sb, p1, p2;
      logic va, vb, vd, wa, wq, sp, ec, ed;
      {fm, p1, p2} = 36'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 10; i++) rd(RA[i], i == 0 ? 32'h7 : 32'h0);
      // Freeze toggles from both modes; bit 16 write attempts must be ignored.
      for (int i = 0; i < 4; i++) begin
         pm = fm;
         fm = {31'h0, ~i[0]};
         wr(`OFS_FREEZE_CTL, 32'h0001_0000 | fm, i[1]);
         rd(`OFS_FREEZE_CTL, pm << 16 | fm);
         chk({31'h0, frz}, fm);
      end
      wr(`OFS_SIZE_CFG, 32'h3, 1'b0);
      rd(`OFS_SIZE_CFG, 32'h7);
      wr(`OFS_SIZE_CFG, 32'h3, 1'b1);
      rd(`OFS_SIZE_CFG, 32'h3);
      chk({29'h0, size_o}, 32'h3);
      // Global commands: user attempt, a write with bit 0 clear, then a supervisor run.
      for (int b = 0; b < 3; b++) begin
         wr(GA[b], 32'h1, 1'b0);
         chk({29'h0, glb_cmd}, b == 0 ? 32'h0 : 32'h1 << b);
         while (glb_cmd !== 3'h0) @(posedge clk_i);
         wr(GA[b], 32'hFFFF_FFFE, 1'b1);
         chk({29'h0, glb_cmd}, 32'h0);
         wr(GA[b], 32'h1, 1'b1);
         rd(GA[b], 32'h1);
         while (glb_cmd !== 3'h0) @(posedge clk_i);
         rd(GA[b], 32'h0);
      end
      // Block operations with random base and count, prompt and slow engine.
      for (int k = 0; k < 6; k++) begin
         slow <= k[0];
         r = nx(r);
         n = {30'h0, r[1:0]} + 32'h1;
         aa = r & 32'hFFFF_FFFC;
         exp_k = k % 3;
         for (int i = 0; i < n; i++) exp_q.push_back(aa + 32'(4 * i));
         wr(BA[k % 3], aa, k[1]);
         wr(CA[k % 3], 32'hA5A5_0000 | n, k[2]);
         if (k[0]) rd(CA[k % 3], n);
         while (blk_req !== 1'b0) @(posedge clk_i);
         chk(exp_q.size(), 32'h0);
         rd(CA[k % 3], 32'h0);
      end
      // Random port pairs and DMA; the stall seen at edge j belongs to edge j-2 stimulus.
      for (int j = 0; j < 400; j++) begin
         @(posedge clk_i);
         r = nx(r);
         {sa, sb, wa, wq, vd, sp} = {r[7:4], r[27], r[28], r[26], &r[31:29]};
         {va, vb} = {r[22] | r[23], r[24] | r[25]};
         aa = al(r, sa);
         ab = al(r >> 10, sb);
         ad = al(r >> 16, 2'h2);
         {pa_vld, pa_we, pa_size, pa_addr} <= {va, wa, sa, aa};
         {pb_vld, pb_we, pb_size, pb_addr} <= {vb, wq, sb, ab};
         {dm_vld, dm_addr, split, big} <= {vd, ad, sp, r[21]};
         ec = va && vb && aa[4:2] == ab[4:2] && !sp && !(aa[31:2] == ab[31:2] &&
            (wa && wq ? (ln(aa, sa) & ln(ab, sb)) == 4'h0 : !wa && !wq));
         ed = vd && (va && aa[4:2] == ad[4:2] || vb && ab[4:2] == ad[4:2]);
         if (j > 1) chk({31'h0, cpu_stall}, {31'h0, p2[1]});
         if (j > 1) chk({31'h0, dma_stall}, {31'h0, p2[0]});
         p2 = p1;
         p1 = {ec, ed};
      end
      end_sim();
   end
endmodule
